//--- verilog/ubs_top.sv
// Purpose: uart buffer status flags with an AHB-Lite register slave
// Assumes: uart side strobes are one-cycle pulses synchronous to hclk
// Notes:   How it works
`include "ubs_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module ubs_top (
    input wire logic hclk,                  // core clock, 100 MHz
    input wire logic hresetn,               // async reset, active low
    input wire logic hsel,                  // slave select
    input wire logic [31:0] haddr,          // byte address
    input wire logic [1:0] htrans,          // transfer type
    input wire logic hwrite,                // write when high
    input wire logic [2:0] hsize,           // word transfers only
    input wire logic [31:0] hwdata,         // write data
    input wire logic hready,                // bus ready in
    output logic hreadyout,                 // always ready
    output logic [31:0] hrdata,             // read data, from flops
    output logic hresp,                     // always OKAY
    input wire logic rx_active,             // receiver taking data
    input wire logic rx_byte_wr,            // byte enters rx buffer
    input wire logic rx_byte_bad,           // that byte had an error
    input wire logic rx_stop_seen,          // stop character seen
    input wire logic rx_preamble_seen,      // preamble character seen
    input wire logic alert_poll_active,     // automatic alert poll
    input wire logic rx_byte_rd,            // host reads an rx byte
    input wire logic tx_active,             // transmitter sending
    input wire logic tx_load_wr,            // host writes a queue byte
    input wire logic tx_load_next,          // host advances load index
    input wire logic tx_send_done,          // send queue fully sent
    output logic tx_send_start,             // start sending, pulse
    output ubs_pkg::ubs_qidx_t tx_send_queue, // queue to send
    output ubs_pkg::ubs_len_t tx_send_len   // bytes in that queue
);
    import ubs_pkg::*;

    ubs_rx_if rx_st ();

    ubs_phase_t phase_r;
    logic [31:0] addr_r;
    logic [31:0] hrdata_r;
    logic ignore_r;
    ubs_qidx_t ld_q_r;
    ubs_qidx_t tx_q_r;
    ubs_len_t qlen_r [`UBS_TXQ_NUM];
    logic tx_ovf_r;
    logic ovf_fresh_r;
    logic tx_busy_r;
    logic sending_r;
    logic accept;
    logic tx_full;
    logic tx_empty;
    logic transmit_stalled_flag;
    logic load_ok;
    logic adv_ok;
    ubs_len_t cur_len;
    ubs_word_t stat_rx;
    ubs_word_t stat_tx;

    // receive buffer tracking
    ubs_rx_tracker u_rx (
        .hclk(hclk),
        .hresetn(hresetn),
        .rx_active(rx_active),
        .rx_byte_wr(rx_byte_wr),
        .rx_byte_bad(rx_byte_bad),
        .rx_stop_seen(rx_stop_seen),
        .rx_preamble_seen(rx_preamble_seen),
        .alert_poll_active(alert_poll_active),
        .rx_byte_rd(rx_byte_rd),
        .st(rx_st.trk)
    );

    // word address match against a register index
    function automatic logic reg_hit(input logic [31:0] a,
                                     input logic [7:0] idx);
        reg_hit = (a == {22'h000000, idx, 2'b00});
    endfunction

    // transmit queue ring state
    assign tx_empty = (ld_q_r == tx_q_r);
    assign tx_full = (ld_q_r == tx_q_r - 2'h1);
    assign cur_len = qlen_r[tx_q_r];
    // stall when rx space cannot take the reply, unless space is ignored
    assign transmit_stalled_flag = !ignore_r &&
                     ({1'b0, rx_st.space} < {2'b00, cur_len} + 9'h001);
    assign load_ok = tx_load_wr &&
                     (ovf_fresh_r || qlen_r[ld_q_r] != `UBS_TXQ_MAX_LEN);
    assign adv_ok = tx_load_next && !tx_full;

    // status words, bit 6 reserved as zero
    always_comb begin
        stat_rx = 8'h00;
        stat_rx[`UBS_RX_ERR_BIT] = rx_st.err;
        stat_rx[`UBS_RX_BUSY_BIT] = rx_st.busy;
        stat_rx[`UBS_RX_IDLE_BIT] = rx_st.idle;
        stat_rx[`UBS_RX_OVF_BIT] = rx_st.ovf;
        stat_rx[`UBS_RX_FULL_BIT] = rx_st.full;
        stat_rx[`UBS_RX_STOP_BIT] = rx_st.stop;
        stat_rx[`UBS_RX_EMPTY_BIT] = rx_st.empty;
        stat_tx = 8'h00;
        stat_tx[`UBS_TRANSMIT_STALLED_FLAG_BIT] = transmit_stalled_flag;
        stat_tx[`UBS_TX_BUSY_BIT] = tx_busy_r;
        stat_tx[`UBS_TX_IDLE_BIT] = !tx_busy_r;
        stat_tx[`UBS_TX_OVF_BIT] = tx_ovf_r;
        stat_tx[`UBS_TX_FULL_BIT] = tx_full;
        stat_tx[`UBS_TRANSMIT_QUEUE_FREE_FLAG_BIT] = !tx_full;
        stat_tx[`UBS_TX_EMPTY_BIT] = tx_empty;
    end

    // bus address phase is taken when selected, active and ready
    assign accept = hsel && htrans[1] && hready;

    // data phase bookkeeping
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            phase_r <= UBS_PH_IDLE;
            addr_r <= '0;
        end else if (hready) begin
            if (accept) begin
                phase_r <= hwrite ? UBS_PH_WRITE : UBS_PH_READ;
                addr_r <= haddr;
            end else begin
                phase_r <= UBS_PH_IDLE;
            end
        end
    end

    // read data captured at the address phase; unmapped reads give zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_r <= '0;
        end else if (accept && !hwrite) begin
            if (reg_hit(haddr, `UBS_IDX_RX_STATUS)) begin
                hrdata_r <= {24'h000000, stat_rx};
            end else if (reg_hit(haddr, `UBS_IDX_TX_STATUS)) begin
                hrdata_r <= {24'h000000, stat_tx};
            end else if (reg_hit(haddr, `UBS_IDX_CTRL)) begin
                hrdata_r <= {31'h00000000, ignore_r};
            end else begin
                hrdata_r <= '0;
            end
        end
    end

    // control register write; status registers ignore writes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ignore_r <= `UBS_CTRL_RST;
        end else begin
            unique case (phase_r)
                UBS_PH_WRITE: begin
                    if (reg_hit(addr_r, `UBS_IDX_CTRL)) begin
                        ignore_r <= hwdata[`UBS_CTRL_IGNORE_BIT];
                    end
                end
                UBS_PH_READ: begin
                    ignore_r <= ignore_r;
                end
                UBS_PH_IDLE: begin
                    ignore_r <= ignore_r;
                end
                default: begin
                    ignore_r <= ignore_r;
                end
            endcase
        end
    end

    assign hrdata = hrdata_r;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // load index advances only into a free queue
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ld_q_r <= '0;
        end else if (adv_ok) begin
            ld_q_r <= ld_q_r + 2'h1;
        end
    end

    // send index advances when a queue has gone out
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_q_r <= '0;
        end else if (tx_send_done && sending_r) begin
            tx_q_r <= tx_q_r + 2'h1;
        end
    end

    // overflow flag and the overwrite mode it opens
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_ovf_r <= 1'b0;
            ovf_fresh_r <= 1'b0;
        end else begin
            if (tx_load_next && tx_full) begin
                tx_ovf_r <= 1'b1;
                ovf_fresh_r <= 1'b1;
            end else if (adv_ok) begin
                tx_ovf_r <= 1'b0;
                ovf_fresh_r <= 1'b0;
            end else if (tx_load_wr) begin
                ovf_fresh_r <= 1'b0;
            end
        end
    end

    // per-queue byte counts
    genvar q;
    generate
        for (q = 0; q < `UBS_TXQ_NUM; q = q + 1) begin : g_queue
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    qlen_r[q] <= '0;
                end else if (tx_send_done && sending_r &&
                             tx_q_r == ubs_qidx_t'(q)) begin
                    qlen_r[q] <= '0;
                end else if (load_ok && ld_q_r == ubs_qidx_t'(q)) begin
                    if (ovf_fresh_r) begin
                        qlen_r[q] <= 6'h01;
                    end else begin
                        qlen_r[q] <= qlen_r[q] + 6'h01;
                    end
                end
            end
        end
    endgenerate

    // a pending queue starts only when not stalled and not already out
    assign tx_send_start = !tx_empty && !sending_r && !tx_active &&
                           !transmit_stalled_flag;
    assign tx_send_queue = tx_q_r;
    assign tx_send_len = cur_len;

    // queue in flight
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sending_r <= 1'b0;
        end else if (tx_send_start) begin
            sending_r <= 1'b1;
        end else if (tx_send_done) begin
            sending_r <= 1'b0;
        end
    end

    // transmitter activity
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_busy_r <= 1'b0;
        end else begin
            tx_busy_r <= tx_active;
        end
    end

    // status values right after reset
    a_reset_values: assert property (@(posedge hclk) disable iff (!hresetn)
        !$past(hresetn) |-> stat_rx == `UBS_RX_STATUS_RST &&
        stat_tx == `UBS_TX_STATUS_RST)
        else $error("status not at reset value after reset");

    // space ignored means never stalled
    a_ignore_no_hold: assert property (@(posedge hclk) disable iff (!hresetn)
        ignore_r |-> !stat_tx[`UBS_TRANSMIT_STALLED_FLAG_BIT])
        else $error("stalled flag set while space is ignored");

    // stalled queue never goes in flight
    a_held_blocks: assert property (@(posedge hclk) disable iff (!hresetn)
        transmit_stalled_flag && !sending_r |=> !sending_r)
        else $error("send started while stalled");

    // overwrite in the rx buffer raises the flag next cycle
    a_rx_ovf_set: assert property (@(posedge hclk) disable iff (!hresetn)
        rx_byte_wr && rx_st.full && !rx_byte_rd |=> rx_st.ovf ##0
        rx_st.full)
        else $error("rx overwrite flag missed");

    // a counted stop marks a readable message
    a_rx_stop_set: assert property (@(posedge hclk) disable iff (!hresetn)
        rx_stop_seen && !alert_poll_active && !rx_st.empty |=>
        rx_st.stop)
        else $error("message done flag missed");

    // stop into an empty buffer or during a poll leaves the flag alone
    a_rx_stop_skip: assert property (@(posedge hclk) disable iff (!hresetn)
        (rx_stop_seen && (rx_st.empty || alert_poll_active) && !rx_st.stop)
        |=> !rx_st.stop)
        else $error("message done flag set by ignored stop");

    // blocked advance raises overflow and keeps the load index
    a_tx_ovf_set: assert property (@(posedge hclk) disable iff (!hresetn)
        tx_load_next && tx_full |=> tx_ovf_r &&
        ld_q_r == $past(ld_q_r))
        else $error("tx overflow not flagged or index moved");

    // free advance moves the load index by one
    a_ld_advance: assert property (@(posedge hclk) disable iff (!hresetn)
        tx_load_next && !tx_full |=> ld_q_r == $past(ld_q_r) + 2'h1 &&
        !stat_tx[`UBS_TX_EMPTY_BIT])
        else $error("load index did not advance");

    // busy and idle are always opposite, one cycle behind activity
    a_busy_idle: assert property (@(posedge hclk) disable iff (!hresetn)
        stat_tx[`UBS_TX_BUSY_BIT] == $past(tx_active) &&
        stat_tx[`UBS_TX_IDLE_BIT] == !$past(tx_active))
        else $error("tx busy or idle flag wrong");

    // receiver busy and idle follow activity one cycle late
    a_rx_busy_idle: assert property (@(posedge hclk) disable iff (!hresetn)
        rx_st.busy == $past(rx_active) &&
        rx_st.idle == !$past(rx_active))
        else $error("rx busy or idle flag wrong");

    // a load after a blocked advance restarts the load queue at one byte
    a_tx_ovf_load: assert property (@(posedge hclk) disable iff (!hresetn)
        tx_load_wr && ovf_fresh_r && !tx_load_next |=>
        qlen_r[ld_q_r] == 6'h01)
        else $error("overflow load did not restart the queue");

    // writes to a status word leave the control bit unchanged
    a_status_ro: assert property (@(posedge hclk) disable iff (!hresetn)
        accept && hwrite && (reg_hit(haddr, `UBS_IDX_RX_STATUS) ||
        reg_hit(haddr, `UBS_IDX_TX_STATUS)) |=>
        ##1 ignore_r == $past(ignore_r, 2))
        else $error("status write changed state");

    // a send finishing on a full ring leaves a queue available and not full
    a_full_avail: assert property (@(posedge hclk) disable iff (!hresetn)
        tx_send_done && sending_r && tx_full && !tx_load_next |=>
        stat_tx[`UBS_TRANSMIT_QUEUE_FREE_FLAG_BIT] && !stat_tx[`UBS_TX_FULL_BIT])
        else $error("queue availability wrong after send");
endmodule
`default_nettype wire

//--- verilog/ubs_consts.svh
// Purpose: offsets, field positions, reset values and sizes for the
//          uart buffer status block
// Assumes: included by bare name from every design file that needs it
// Notes:   register byte address is four times the register index
`ifndef UBS_CONSTS_SVH
`define UBS_CONSTS_SVH

// register indices, byte address = index * 4
`define UBS_IDX_RX_STATUS 8'h00
`define UBS_IDX_TX_STATUS 8'h02
`define UBS_IDX_CTRL 8'h04

// receive status fields
`define UBS_RX_ERR_BIT 7
`define UBS_RX_BUSY_BIT 5
`define UBS_RX_IDLE_BIT 4
`define UBS_RX_OVF_BIT 3
`define UBS_RX_FULL_BIT 2
`define UBS_RX_STOP_BIT 1
`define UBS_RX_EMPTY_BIT 0

// transmit status fields
`define UBS_TRANSMIT_STALLED_FLAG_BIT 7
`define UBS_TX_BUSY_BIT 5
`define UBS_TX_IDLE_BIT 4
`define UBS_TX_OVF_BIT 3
`define UBS_TX_FULL_BIT 2
`define UBS_TRANSMIT_QUEUE_FREE_FLAG_BIT 1
`define UBS_TX_EMPTY_BIT 0

// control register field
`define UBS_CTRL_IGNORE_BIT 0

// reset values
`define UBS_RX_STATUS_RST 8'h11
`define UBS_TX_STATUS_RST 8'h13
`define UBS_CTRL_RST 1'b0

// sizes
`define UBS_RX_DEPTH 128
`define UBS_RX_DEPTH_CNT 8'h80
`define UBS_TXQ_NUM 4
`define UBS_TXQ_MAX_LEN 6'h20

`endif

//--- verilog/ubs_pkg.sv
// Purpose: shared types of the uart buffer status block
// Assumes: nothing
// Notes:   numeric constants live in ubs_consts.svh
package ubs_pkg;
    typedef logic [6:0] ubs_ridx_t;   // receive buffer index
    typedef logic [7:0] ubs_cnt_t;    // byte count 0..128
    typedef logic [1:0] ubs_qidx_t;   // transmit queue index
    typedef logic [5:0] ubs_len_t;    // queue length 0..32
    typedef logic [7:0] ubs_word_t;   // status register contents

    // bus data phase kind
    typedef enum logic [1:0] {
        UBS_PH_IDLE = 2'b00,
        UBS_PH_WRITE = 2'b01,
        UBS_PH_READ = 2'b10
    } ubs_phase_t;
endpackage

//--- verilog/ubs_rx_if.sv
// Purpose: receive buffer state passed from the tracker to the top
// Assumes: one driver, the tracker
// Notes:   all members come from flops or simple logic on flops (compares, an inversion, one subtraction)
`timescale 1ns/1ps
`default_nettype none
interface ubs_rx_if;
    ubs_pkg::ubs_cnt_t space;   // empty bytes left
    logic err;                  // byte last read was bad
    logic busy;                 // receiver active
    logic idle;                 // receiver quiet
    logic ovf;                  // overwrite happened
    logic full;                 // no space left
    logic stop;                 // framed message readable
    logic empty;                // no unread data

    modport trk (output space, err, busy, idle, ovf, full, stop, empty);
    modport top (input space, err, busy, idle, ovf, full, stop, empty);
endinterface
`default_nettype wire

//--- verilog/ubs_rx_tracker.sv
// Purpose: tracks receive buffer fill, per-byte marks and receive flags
// Assumes: strobes are one-cycle pulses synchronous to hclk
// Notes:   data storage itself sits outside; only indices and marks here
`include "ubs_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module ubs_rx_tracker (
    input wire logic hclk,              // core clock
    input wire logic hresetn,           // async reset, active low
    input wire logic rx_active,         // receiver is taking data
    input wire logic rx_byte_wr,        // a byte enters the buffer
    input wire logic rx_byte_bad,       // that byte had a line error
    input wire logic rx_stop_seen,      // stop character received
    input wire logic rx_preamble_seen,  // preamble character received
    input wire logic alert_poll_active, // automatic alert poll running
    input wire logic rx_byte_rd,        // host reads one byte
    ubs_rx_if.trk st                    // status towards the top
);
    import ubs_pkg::*;

    logic [`UBS_RX_DEPTH-1:0] err_mem_r;
    logic [`UBS_RX_DEPTH-1:0] last_mem_r;
    ubs_ridx_t wr_idx_r;
    ubs_ridx_t rd_idx_r;
    ubs_ridx_t last_wr_idx;
    ubs_cnt_t count_r;
    ubs_cnt_t msg_cnt_r;
    logic err_r;
    logic ovf_r;
    logic stop_r;
    logic busy_r;
    logic do_rd;
    logic do_wr;
    logic overwrite;
    logic stop_ok;
    logic rd_last;

    // event qualification
    assign do_rd = rx_byte_rd && (count_r != 8'h00);
    assign overwrite = rx_byte_wr && (count_r == `UBS_RX_DEPTH_CNT) && !do_rd;
    assign do_wr = rx_byte_wr && !overwrite;
    assign last_wr_idx = wr_idx_r - 7'h01;
    // polls and stops into an empty buffer never count as messages
    assign stop_ok = rx_stop_seen && !alert_poll_active &&
                     (count_r != 8'h00);
    assign rd_last = do_rd && last_mem_r[rd_idx_r];

    // per-byte error and end-of-message marks, indexed storage
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            err_mem_r <= '0;
            last_mem_r <= '0;
        end else begin
            if (rx_byte_wr) begin
                err_mem_r[wr_idx_r] <= rx_byte_bad;
                last_mem_r[wr_idx_r] <= 1'b0;
            end
            if (stop_ok) begin
                last_mem_r[last_wr_idx] <= 1'b1;
            end
        end
    end

    // indices and fill count; overwrite keeps both indices
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_idx_r <= '0;
            rd_idx_r <= '0;
            count_r <= '0;
        end else begin
            if (do_wr) begin
                wr_idx_r <= wr_idx_r + 7'h01;
            end
            if (do_rd) begin
                rd_idx_r <= rd_idx_r + 7'h01;
            end
            if (do_wr && !do_rd) begin
                count_r <= count_r + 8'h01;
            end else if (do_rd && !do_wr) begin
                count_r <= count_r - 8'h01;
            end
        end
    end

    // error flag follows the byte as it is read, not as it arrives
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            err_r <= 1'b0;
        end else if (do_rd) begin
            err_r <= err_mem_r[rd_idx_r];
        end
    end

    // overwrite flag: set wins, a read frees a slot and clears it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ovf_r <= 1'b0;
        end else if (overwrite) begin
            ovf_r <= 1'b1;
        end else if (do_rd) begin
            ovf_r <= 1'b0;
        end
    end

    // unread message count and the message done flag
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            msg_cnt_r <= '0;
            stop_r <= 1'b0;
        end else begin
            if (stop_ok && !rd_last) begin
                msg_cnt_r <= msg_cnt_r + 8'h01;
            end else if (rd_last && !stop_ok && msg_cnt_r != 8'h00) begin
                msg_cnt_r <= msg_cnt_r - 8'h01;
            end
            if (stop_ok) begin
                stop_r <= 1'b1;
            end else if (rx_preamble_seen ||
                         (rd_last && msg_cnt_r == 8'h01)) begin
                stop_r <= 1'b0;
            end
        end
    end

    // receiver activity
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            busy_r <= 1'b0;
        end else begin
            busy_r <= rx_active;
        end
    end

    // status towards the top
    assign st.space = `UBS_RX_DEPTH_CNT - count_r;
    assign st.full = (count_r == `UBS_RX_DEPTH_CNT);
    assign st.empty = (count_r == 8'h00);
    assign st.err = err_r;
    assign st.busy = busy_r;
    assign st.idle = !busy_r;
    assign st.ovf = ovf_r;
    assign st.stop = stop_r;
endmodule
`default_nettype wire

//--- tb/ubs_tx_partner.sv
// Purpose: far-side transmitter, runs each queue the block starts
// Assumes: tx_send_start is sampled at rising edges of hclk
// Notes: send time is random, 1 to 8 cycles
`timescale 1ns/1ps
`default_nettype none
module ubs_tx_partner (
    input wire logic hclk,          // core clock
    input wire logic hresetn,       // async reset, active low
    input wire logic tx_send_start, // block starts a queue
    output logic tx_active,         // line busy
    output logic tx_send_done,      // queue finished, pulse
    output logic [7:0] n_sent       // queues finished so far
);
    logic [3:0] left_r;
    // one send at a time, done pulses as the line goes quiet
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_active <= 1'b0;
            tx_send_done <= 1'b0;
            left_r <= 4'h0;
            n_sent <= 8'h00;
        end else begin
            tx_send_done <= 1'b0;
            if (!tx_active && !tx_send_done && tx_send_start) begin
                tx_active <= 1'b1;
                left_r <= 4'($urandom_range(8, 1));
            end else if (tx_active && left_r == 4'h1) begin
                tx_active <= 1'b0;
                tx_send_done <= 1'b1;
                n_sent <= n_sent + 8'h01;
            end else if (tx_active) begin
                left_r <= left_r - 4'h1;
            end
        end
    end
endmodule
`default_nettype wire

//--- tb/tb_ubs_top.sv
// Purpose: self-checking bench for ubs_top
// Assumes: single slave, so hready is hreadyout
// Notes: reads queue their expected word, a monitor compares
`include "ubs_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_ubs_top;
    localparam logic [7:0] RX = `UBS_IDX_RX_STATUS;
    localparam logic [7:0] TX = `UBS_IDX_TX_STATUS;
    localparam logic [7:0] CT = `UBS_IDX_CTRL;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, rd_dph = 0;
    logic rx_active = 0, alert_poll_active = 0;
    logic [31:0] haddr = 0, hwdata = 0;
    logic [1:0] htrans = 0;
    logic [6:0] stb = 0; // wr bad stop pre rd load_wr load_next
    wire logic hreadyout, hresp, tx_active, tx_send_done, tx_send_start;
    wire logic [31:0] hrdata;
    wire logic [1:0] tx_send_queue;
    wire logic [5:0] tx_send_len;
    wire logic [7:0] n_sent;
    logic [31:0] exp_q[$];
    int n_mismatch = 0, cmp_count = 0;
    initial forever #5 hclk = ~hclk;
    ubs_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(hresp), .rx_active(rx_active),
        .rx_byte_wr(stb[0]), .rx_byte_bad(stb[1]), .rx_stop_seen(stb[2]),
        .rx_preamble_seen(stb[3]), .alert_poll_active(alert_poll_active),
        .rx_byte_rd(stb[4]), .tx_active(tx_active), .tx_load_wr(stb[5]),
        .tx_load_next(stb[6]), .tx_send_done(tx_send_done),
        .tx_send_start(tx_send_start), .tx_send_queue(tx_send_queue),
        .tx_send_len(tx_send_len));
    ubs_tx_partner far_end (.hclk(hclk), .hresetn(hresetn),
        .tx_send_start(tx_send_start), .tx_active(tx_active),
        .tx_send_done(tx_send_done), .n_sent(n_sent));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // bounded wait for an edge with hready high
    task automatic wait_rdy();
        int i;
        i = 0;
        do begin
            @(posedge hclk);
            i++;
        end while (hreadyout !== 1'b1 && i < 16);
        if (hreadyout !== 1'b1) begin
            n_mismatch++;
            report_and_stop();
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] idx,
                       input logic [31:0] d);
        haddr <= {22'h0, idx, 2'b00};
        hwrite <= w;
        htrans <= 2'b10;
        hsel <= 1'b1;
        wait_rdy();
        htrans <= 2'b00;
        hwdata <= d;
        rd_dph <= !w;
        wait_rdy();
        rd_dph <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] idx, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, idx, 32'h0);
    endtask
    task automatic pulse(input logic [6:0] m);
        stb <= m;
        @(posedge hclk);
        stb <= 7'h00;
        @(posedge hclk);
    endtask
    task automatic rst_chk();
        rd(RX, 32'h11);
        rd(TX, 32'h13);
        rd(CT, 32'h0);
        rd(8'h03, 32'h0);
    endtask
    // read data is taken at the data phase edge
    always @(posedge hclk) begin
        if (rd_dph && hreadyout) begin
            check(hrdata, exp_q.pop_front());
            check({31'h0, hresp}, 32'h0);
        end
    end
    // queues go out in ring order, each holding the one byte loaded
    always @(posedge hclk) begin
        if (hresetn && tx_send_start) begin
            check({30'h0, tx_send_queue}, {30'h0, n_sent[1:0]});
            check({26'h0, tx_send_len}, 32'h1);
        end
    end
    initial begin
        void'($urandom(32'hcabf4f1d));
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        rst_chk();
        bus(1'b1, RX, $urandom());
        bus(1'b1, TX, $urandom());
        rd(RX, 32'h11);
        rd(TX, 32'h13);
        rx_active <= 1'b1;
        repeat (2) @(posedge hclk);
        rd(RX, 32'h21);
        rx_active <= 1'b0;
        pulse(7'h04);
        rd(RX, 32'h11);
        pulse(7'h03);
        pulse(7'h04);
        rd(RX, 32'h12);
        pulse(7'h10);
        rd(RX, 32'h91);
        alert_poll_active <= 1'b1;
        pulse(7'h01);
        pulse(7'h04);
        alert_poll_active <= 1'b0;
        rd(RX, 32'h90);
        pulse(7'h04);
        rd(RX, 32'h92);
        pulse(7'h08);
        rd(RX, 32'h90);
        pulse(7'h10);
        rd(RX, 32'h11);
        stb <= 7'h01;
        repeat (129) @(posedge hclk);
        stb <= 7'h00;
        rd(RX, 32'h1C);
        rd(TX, 32'h93);
        repeat (3) begin
            pulse(7'h20);
            pulse(7'h40);
        end
        repeat (2) pulse(7'h20);
        pulse(7'h40);
        rd(TX, 32'h9C);
        check({31'h0, tx_send_start}, 32'h0);
        pulse(7'h20);
        bus(1'b1, CT, 32'h1);
        for (int i = 0; i < 2000 && n_sent !== 8'h03; i++) @(posedge hclk);
        check({24'h0, n_sent}, 32'h3);
        if (n_sent !== 8'h03) report_and_stop();
        repeat (2) @(posedge hclk);
        rd(TX, 32'h1B);
        rd(RX, 32'h1C);
        pulse(7'h10);
        rd(RX, 32'h10);
        hresetn <= 1'b0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        rst_chk();
        report_and_stop();
    end
endmodule
`default_nettype wire
